// [core/tws_pkg.sv]
package tws_pkg;

	// =========================================================
	// device address word layout
	localparam logic [3:0] TWS_DEV_TYPE      = 4'hA;  // fixed 1010 pattern
	localparam int         TWS_TYPE_MSB      = 7;
	localparam int         TWS_TYPE_LSB      = 4;
	localparam int         TWS_SEL_HIGH_BIT  = 3;
	localparam int         TWS_SEL_MID_BIT   = 2;
	localparam int         TWS_SEL_LOW_BIT   = 1;
	localparam int         TWS_RW_BIT        = 0;

	// =========================================================
	// variants: 0=1K 1=2K 2=4K 3=8K 4=16K
	localparam logic [2:0] TWS_VAR_1K        = 3'h0;
	localparam logic [2:0] TWS_VAR_2K        = 3'h1;
	localparam logic [2:0] TWS_VAR_4K        = 3'h2;
	localparam logic [2:0] TWS_VAR_8K        = 3'h3;
	localparam logic [2:0] TWS_VAR_16K       = 3'h4;
	localparam int         TWS_MEM_WORDS     = 2048;
	localparam int         TWS_ADDR_W        = 11;
	localparam int         TWS_WORD_W        = 8;
	localparam logic [3:0] TWS_PAGE_MASK_SM  = 4'h7;  // 8-byte page
	localparam logic [3:0] TWS_PAGE_MASK_LG  = 4'hF;  // 16-byte page
	localparam logic [3:0] TWS_BITS_PER_WORD = 4'h8;
	localparam logic [3:0] TWS_ACK_SLOT      = 4'h8;  // ninth scl cycle

	// =========================================================
	// timing
	localparam int         TWS_CLK_HZ        = 20000000;
	localparam int         TWS_PROG_TIME_US  = 5000;  // internal_program_time, 5 ms max
	localparam int         TWS_PROG_CYC      = TWS_PROG_TIME_US * (TWS_CLK_HZ / 1000000);
	localparam int         TWS_SCL_DIV       = 10;    // quarter period of master scl in clocks
	localparam int         TWS_RECOVER_CLKS  = 9;

endpackage : tws_pkg

// [core/tws_if.sv]
`timescale 1ns/1ps
// =========================================================
// two-wire link; open drain levels resolved from the enables
interface tws_if;
	logic scl_oe;   // master pulls scl low
	logic sda_m_oe; // master pulls sda low
	logic sda_s_oe; // slave pulls sda low
	logic scl;
	logic sda;

	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);

	modport device (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface : tws_if

// [core/tws_slave.sv]
`timescale 1ns/1ps
// How it works
// - sda change with scl high is condition
// - sda fall, scl high: start
// - sda rise, scl high: stop, standby
// - ack each received byte in ninth cycle
// - standby at reset and after stop
// - master recovers bus with nine clocks
// - programming finishes within 5 ms
// - address word opens with 1010
// - small parts compare all three selects
// - 4K compares two selects, one page bit
// - 8K compares one select, two page bits
// - 16K: three page bits, upper address
// - eighth address bit selects read/write
// - ack match, mismatch returns to standby
// - byte write: address, data, stop
// - self-timed write ignores all inputs
// - page size 8 or 16 bytes
// - page write sends more bytes, then stop
// - only low address bits increment, wrap
// - silent while write cycle runs
// - sample on scl rise, drive ack on fall
module tws_slave
	import tws_pkg::*;
#(
	parameter logic [2:0] VARIANT  = TWS_VAR_2K,
	parameter int         PROG_CYC = TWS_PROG_CYC
)(
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        chip_select_pin_high_i,
	input  wire logic        chip_select_pin_mid_i,
	input  wire logic        chip_select_pin_low_i,
	output logic             standby_o,
	output logic             prog_busy_o,
	tws_if.device            bus
);

	typedef enum logic [5:0] {
		TWS_ST_IDLE = 6'h01,
		TWS_ST_DEV  = 6'h02,
		TWS_ST_WADR = 6'h04,
		TWS_ST_DATA = 6'h08,
		TWS_ST_RD   = 6'h10,
		TWS_ST_PROG = 6'h20
	} tws_state_t;

	// =========================================================
	// pin synchronisers
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       scl_d_r;
	logic       sda_d_r;

	// two flops before logic; first flop read only by second
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], bus.scl};
			sda_sync_r <= {sda_sync_r[0], bus.sda};
			scl_d_r    <= scl_sync_r[1];
			sda_d_r    <= sda_sync_r[1];
		end
	end

	// straps are pins too: two flops before the address compare reads them
	logic [2:0] sel_meta_r;
	logic [2:0] sel_pin_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			sel_meta_r <= 3'h0;
			sel_pin_r  <= 3'h0;
		end else begin
			sel_meta_r <= {chip_select_pin_high_i, chip_select_pin_mid_i,
				chip_select_pin_low_i};
			sel_pin_r  <= sel_meta_r;
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_s     = scl_sync_r[1];
	assign sda_s     = sda_sync_r[1];
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// =========================================================
	// select compare and page bit extraction per variant
	logic [7:0]  shift_r;
	logic        sel_match;
	logic [2:0]  page_hi;
	logic [3:0]  page_mask;
	always_comb begin
		sel_match = (shift_r[TWS_TYPE_MSB:TWS_TYPE_LSB] == TWS_DEV_TYPE);
		page_hi   = 3'h0;
		page_mask = TWS_PAGE_MASK_LG;
		case (VARIANT)
			TWS_VAR_1K, TWS_VAR_2K: begin
				sel_match = sel_match
					& (shift_r[TWS_SEL_HIGH_BIT] == sel_pin_r[2])
					& (shift_r[TWS_SEL_MID_BIT] == sel_pin_r[1])
					& (shift_r[TWS_SEL_LOW_BIT] == sel_pin_r[0]);
				page_mask = TWS_PAGE_MASK_SM;
			end
			TWS_VAR_4K: begin
				sel_match = sel_match
					& (shift_r[TWS_SEL_HIGH_BIT] == sel_pin_r[2])
					& (shift_r[TWS_SEL_MID_BIT] == sel_pin_r[1]);
				page_hi   = {2'h0, shift_r[TWS_SEL_LOW_BIT]};
			end
			TWS_VAR_8K: begin
				sel_match = sel_match
					& (shift_r[TWS_SEL_HIGH_BIT] == sel_pin_r[2]);
				page_hi   = {1'b0, shift_r[TWS_SEL_MID_BIT:TWS_SEL_LOW_BIT]};
			end
			default: begin
				page_hi   = shift_r[TWS_SEL_HIGH_BIT:TWS_SEL_LOW_BIT];
			end
		endcase
	end

	// =========================================================
	// byte engine and control state
	tws_state_t            state_r;
	logic [3:0]            bit_cnt_r;
	logic [TWS_ADDR_W-1:0] addr_r;
	logic                  sda_oe_r;
	logic                  wrote_r;
	logic [22:0]           prog_cnt_r;
	logic [TWS_WORD_W-1:0] mem [TWS_MEM_WORDS];
	logic                  mem_we;

	// a data byte is committed at the fall that opens its ack slot
	assign mem_we = (state_r == TWS_ST_DATA) && scl_fall && (bit_cnt_r == TWS_ACK_SLOT);

	// written bytes go straight into the array; the timed cycle then only blocks access
	always_ff @(posedge ref_clk_i) begin
		if (mem_we) begin
			mem[addr_r] <= shift_r;
		end
	end

	// receive shift register, sampled on scl rise
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			shift_r <= 8'h00;
		end else if (scl_rise && bit_cnt_r < TWS_BITS_PER_WORD) begin
			shift_r <= {shift_r[6:0], sda_s};
		end
	end

	// main sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_r    <= TWS_ST_IDLE;
			bit_cnt_r  <= 4'h0;
			addr_r     <= '0;
			sda_oe_r   <= 1'b0;
			wrote_r    <= 1'b0;
			prog_cnt_r <= '0;
		end else if (state_r == TWS_ST_PROG) begin
			// inputs ignored until the timed write ends
			sda_oe_r <= 1'b0;
			if (prog_cnt_r == 23'(PROG_CYC - 1)) begin
				state_r    <= TWS_ST_IDLE;
				prog_cnt_r <= '0;
			end else begin
				prog_cnt_r <= prog_cnt_r + 23'h1;
			end
		end else if (stop_det) begin
			sda_oe_r  <= 1'b0;
			bit_cnt_r <= 4'h0;
			state_r   <= wrote_r ? TWS_ST_PROG : TWS_ST_IDLE;
			wrote_r   <= 1'b0;
		end else if (start_det) begin
			sda_oe_r  <= 1'b0;
			bit_cnt_r <= 4'h0;
			state_r   <= wrote_r ? TWS_ST_PROG : TWS_ST_DEV;
			wrote_r   <= 1'b0;
		end else if (scl_fall) begin
			// eighth bit is in: decide now so the ack stands before the ninth rise
			if (bit_cnt_r == TWS_ACK_SLOT) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
				sda_oe_r  <= 1'b1;
				case (state_r)
					TWS_ST_DEV: begin
						if (!sel_match) begin
							// no ack; the slave drops back to standby
							sda_oe_r <= 1'b0;
							state_r  <= TWS_ST_IDLE;
						end else if (shift_r[TWS_RW_BIT]) begin
							state_r <= TWS_ST_RD;
							addr_r  <= {page_hi, addr_r[TWS_WORD_W-1:0]};
						end else begin
							state_r <= TWS_ST_WADR;
							addr_r  <= TWS_ADDR_W'({page_hi, 8'h00});
						end
					end
					TWS_ST_WADR: begin
						addr_r  <= {addr_r[TWS_ADDR_W-1:TWS_WORD_W], shift_r};
						state_r <= TWS_ST_DATA;
					end
					TWS_ST_DATA: begin
						wrote_r <= 1'b1;
						addr_r  <= {addr_r[10:4],
							(addr_r[3:0] & ~page_mask)
							| ((addr_r[3:0] + 4'h1) & page_mask)};
					end
					default: begin
						sda_oe_r <= 1'b0;
						state_r  <= TWS_ST_IDLE;
					end
				endcase
			end else if (bit_cnt_r > TWS_ACK_SLOT) begin
				// ninth clock over: release sda and count the next word from zero
				sda_oe_r  <= 1'b0;
				bit_cnt_r <= 4'h0;
			end
		end else if (scl_rise && state_r != TWS_ST_IDLE && state_r != TWS_ST_RD) begin
			// count the eight data bits; the ninth rise only clocks the ack
			if (bit_cnt_r < TWS_BITS_PER_WORD) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end
	end

	// =========================================================
	// outputs
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			standby_o   <= 1'b1;
			prog_busy_o <= 1'b0;
		end else begin
			standby_o   <= (state_r == TWS_ST_IDLE);
			prog_busy_o <= (state_r == TWS_ST_PROG);
		end
	end

	// straight from the flop so the pin never glitches
	assign bus.sda_s_oe = sda_oe_r;

endmodule : tws_slave

// [core/tws_master.sv]
`timescale 1ns/1ps
module tws_master
	import tws_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        cmd_valid_i,   // one-cycle pulse
	input  wire logic        cmd_start_i,   // send start before byte
	input  wire logic        cmd_stop_i,    // send stop after byte
	input  wire logic        cmd_recover_i, // run nine-clock recovery first
	input  wire logic [7:0]  cmd_data_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             ack_o,         // 1 = slave acknowledged
	tws_if.master            bus
);

	typedef enum logic [6:0] {
		TWM_IDLE  = 7'h01,
		TWM_REC   = 7'h02,
		TWM_START = 7'h04,
		TWM_BIT   = 7'h08,
		TWM_ACK   = 7'h10,
		TWM_STOP  = 7'h20,
		TWM_DONE  = 7'h40
	} twm_state_t;

	// =========================================================
	// sda synchroniser
	logic [1:0] sda_sync_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			sda_sync_r <= 2'h3;
		end else begin
			sda_sync_r <= {sda_sync_r[0], bus.sda};
		end
	end

	// =========================================================
	// sequencer; each bit is four quarter phases of TWS_SCL_DIV clocks
	twm_state_t state_r;
	logic [7:0] div_r;
	logic [1:0] ph_r;
	logic [3:0] cnt_r;
	logic [7:0] data_r;
	logic       stop_r;
	logic       start_r;
	logic       scl_oe_r;
	logic       sda_oe_r;
	logic       tick;

	assign tick = (div_r == 8'(TWS_SCL_DIV - 1));

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || state_r == TWM_IDLE) begin
			div_r <= 8'h00;
		end else begin
			div_r <= tick ? 8'h00 : div_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_r  <= TWM_IDLE;
			ph_r     <= 2'h0;
			cnt_r    <= 4'h0;
			data_r   <= 8'h00;
			stop_r   <= 1'b0;
			start_r  <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			busy_o   <= 1'b0;
			done_o   <= 1'b0;
			ack_o    <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				TWM_IDLE: begin
					if (cmd_valid_i) begin
						busy_o  <= 1'b1;
						data_r  <= cmd_data_i;
						stop_r  <= cmd_stop_i;
						start_r <= cmd_start_i;
						ph_r    <= 2'h0;
						cnt_r   <= 4'h0;
						state_r <= cmd_recover_i ? TWM_REC
							: (cmd_start_i ? TWM_START : TWM_BIT);
					end
				end
				TWM_REC: if (tick) begin
					// clock up to nine times until sda seen high
					sda_oe_r <= 1'b0;
					ph_r     <= ph_r + 2'h1;
					scl_oe_r <= (ph_r == 2'h3 || ph_r == 2'h0);
					if (ph_r == 2'h2 && (sda_sync_r[1] ||
						cnt_r == 4'(TWS_RECOVER_CLKS - 1))) begin
						state_r <= start_r ? TWM_START : TWM_BIT;
						ph_r    <= 2'h0;
						cnt_r   <= 4'h0;
					end else if (ph_r == 2'h3) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				TWM_START: if (tick) begin
					// scl high, then sda falls while scl high
					ph_r <= ph_r + 2'h1;
					case (ph_r)
						2'h0: begin
							scl_oe_r <= 1'b0;
							sda_oe_r <= 1'b0;
						end
						2'h1: sda_oe_r <= 1'b1;
						2'h2: scl_oe_r <= 1'b1;
						default: state_r <= TWM_BIT;
					endcase
				end
				TWM_BIT: if (tick) begin
					// sda changes only while scl low
					ph_r <= ph_r + 2'h1;
					case (ph_r)
						2'h0: begin
							scl_oe_r <= 1'b1;
							sda_oe_r <= ~data_r[7];
						end
						2'h1: scl_oe_r <= 1'b0;
						2'h2: scl_oe_r <= 1'b0;
						default: begin
							scl_oe_r <= 1'b1;
							data_r   <= {data_r[6:0], 1'b0};
							cnt_r    <= cnt_r + 4'h1;
							if (cnt_r == TWS_BITS_PER_WORD - 4'h1) begin
								state_r <= TWM_ACK;
							end
						end
					endcase
				end
				TWM_ACK: if (tick) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
						2'h0: begin
							scl_oe_r <= 1'b1;
							sda_oe_r <= 1'b0;
						end
						2'h1: scl_oe_r <= 1'b0;
						2'h2: ack_o <= ~sda_sync_r[1];
						default: begin
							scl_oe_r <= 1'b1;
							state_r  <= stop_r ? TWM_STOP : TWM_DONE;
						end
					endcase
				end
				TWM_STOP: if (tick) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
						2'h0: sda_oe_r <= 1'b1;
						2'h1: scl_oe_r <= 1'b0;
						2'h2: sda_oe_r <= 1'b0;
						default: state_r <= TWM_DONE;
					endcase
				end
				TWM_DONE: begin
					busy_o  <= 1'b0;
					done_o  <= 1'b1;
					state_r <= TWM_IDLE;
				end
				default: state_r <= TWM_IDLE;
			endcase
		end
	end

	assign bus.scl_oe   = scl_oe_r;
	assign bus.sda_m_oe = sda_oe_r;

endmodule : tws_master

// [tb/tws_asserts.sv]
`timescale 1ns/1ps
// =========================================================
// protocol checker standing beside the two-wire link
module tws_asserts #(
	parameter int PROG_CYC = 1500
)(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic standby_o,
	input wire logic prog_busy_o
);
	logic [31:0] busy_cnt_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	// =========================================================
	// length of the timed write; a plain repetition would be far too long
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || !prog_busy_o)
			busy_cnt_r <= 32'h0;
		else
			busy_cnt_r <= busy_cnt_r + 32'h1;
	end

	// =========================================================
	// assertions
	slave_data_low_a: assert property (
		$changed(sda_s_oe) |-> !scl) else $error("slave moved sda with scl high");
	ack_on_rise_a: assert property (
		$rose(sda_s_oe) |-> ##[1:40] ($rose(scl) && sda_s_oe)) else $error("ack not held at rise");
	ack_release_a: assert property (
		sda_s_oe && $fell(scl) |-> ##[0:15] !sda_s_oe) else $error("ack not released");
	master_free_a: assert property (
		sda_s_oe && $rose(scl) |-> !sda_m_oe) else $error("master drove sda in ack slot");
	prog_silent_a: assert property (
		prog_busy_o |-> !sda_s_oe && !standby_o) else $error("slave active in timed write");
	prog_len_a: assert property (
		busy_cnt_r <= 32'(PROG_CYC)) else $error("timed write too long");
	prog_after_stop_a: assert property (
		$rose(prog_busy_o) |-> scl && sda) else $error("timed write began on a busy bus");
	prog_end_standby_a: assert property (
		$fell(prog_busy_o) |-> ##[0:4] standby_o) else $error("no standby after timed write");
	stop_idle_a: assert property (
		scl && $past(scl) && $rose(sda) && !prog_busy_o |-> ##[1:8] (standby_o || prog_busy_o))
		else $error("stop did not idle the slave");
	standby_quiet_a: assert property (
		standby_o |-> !sda_s_oe) else $error("slave drove sda in standby");
	reset_standby_a: assert property (
		$rose(rstn_i) |-> standby_o && !prog_busy_o) else $error("reset state wrong");

	// main scenarios reached
	cover property ($rose(sda_s_oe));
	cover property ($rose(prog_busy_o));
	cover property ($fell(prog_busy_o));
	cover property (scl && $rose(sda));
	cover property (scl_oe && sda_s_oe);
endmodule // tws_asserts

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import tws_pkg::*;
	localparam int PROG_SIM = 1500; // shortened timed write
	logic       ref_clk_i, rstn_i, cmd_valid, cmd_start, cmd_stop, cmd_recover;
	logic [7:0] cmd_data, dev;
	logic [2:0] sel_pins;
	logic       standby, prog_busy, busy, done, ack;
	logic       exp_q[$];
	logic [7:0] pg [10];
	int         n_errors, samples_checked, i, k;

	tws_if tws_if_i();
	tws_slave #(.VARIANT(TWS_VAR_2K), .PROG_CYC(PROG_SIM)) tws_slave_i (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .chip_select_pin_high_i(sel_pins[2]),
		.chip_select_pin_mid_i(sel_pins[1]), .chip_select_pin_low_i(sel_pins[0]),
		.standby_o(standby), .prog_busy_o(prog_busy), .bus(tws_if_i.device));
	tws_master tws_master_i (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid), .cmd_start_i(cmd_start),
		.cmd_stop_i(cmd_stop), .cmd_recover_i(cmd_recover), .cmd_data_i(cmd_data),
		.busy_o(busy), .done_o(done), .ack_o(ack), .bus(tws_if_i.master));
	tws_asserts #(.PROG_CYC(PROG_SIM)) tws_asserts_i (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_oe(tws_if_i.scl_oe),
		.sda_m_oe(tws_if_i.sda_m_oe), .sda_s_oe(tws_if_i.sda_s_oe), .scl(tws_if_i.scl),
		.sda(tws_if_i.sda), .standby_o(standby), .prog_busy_o(prog_busy));

	// =========================================================
	// clock, 50 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	// one byte through the master; the expected ack is noted first
	task automatic xfer(input logic st, input logic sp, input logic rc, input logic [7:0] d,
			input logic ex);
		exp_q.push_back(ex);
		tick(1);
		cmd_valid = 1'b1;
		cmd_start = st;
		cmd_stop = sp;
		cmd_recover = rc;
		cmd_data = d;
		tick(1);
		cmd_valid = 1'b0;
		// bounded wait; a hang is left to the watchdog
		for (int n = 0; n < 4000; n++) begin
			tick(1);
			if (done === 1'b1) break;
		end
	endtask

	task automatic prog_rise();
		for (int n = 0; n < 20 && prog_busy !== 1'b1; n++) tick(1);
		check(prog_busy, 1'b1);
		check(standby, 1'b0);
	endtask

	task automatic prog_fall();
		for (int n = 0; n < PROG_SIM + 20 && prog_busy === 1'b1; n++) tick(1);
		check(prog_busy, 1'b0);
		tick(4);
		check(standby, 1'b1);
	endtask

	// =========================================================
	// result watcher: every done pulse retires the oldest note
	always begin
		@(posedge ref_clk_i);
		#2;
		if (done === 1'b1) check(ack, exp_q.pop_front());
	end

	// watchdog, well beyond the expected run of about 13k cycles
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		n_errors++;
		conclude();
	end

	// =========================================================
	// main sequence
	initial begin
		n_errors = 0;
		samples_checked = 0;
		rstn_i = 1'b0;
		cmd_valid = 1'b0;
		cmd_start = 1'b0;
		cmd_stop = 1'b0;
		cmd_recover = 1'b0;
		cmd_data = 8'h00;
		void'($urandom(32'hFE654ACE));
		sel_pins = 3'($urandom);
		tick(4);
		rstn_i = 1'b1;
		tick(1);
		check(standby, 1'b1);
		check(prog_busy, 1'b0);
		// byte write, then polls during and after the timed write
		xfer(1'b1, 1'b0, 1'b0, {TWS_DEV_TYPE, sel_pins, 1'b0}, 1'b1);
		xfer(1'b0, 1'b0, 1'b0, 8'h3C, 1'b1);
		xfer(1'b0, 1'b1, 1'b0, 8'h5A, 1'b1);
		check(tws_slave_i.mem[11'h03C], 8'h5A);
		prog_rise();
		xfer(1'b1, 1'b1, 1'b0, {TWS_DEV_TYPE, sel_pins, 1'b1}, 1'b0);
		prog_fall();
		xfer(1'b1, 1'b1, 1'b0, {TWS_DEV_TYPE, sel_pins, 1'b1}, 1'b1);
		tick(6);
		check(standby, 1'b1);
		// address matching over random straps and words
		for (k = 0; k < 8; k++) begin
			sel_pins = 3'($urandom);
			dev = {(k[0] ? TWS_DEV_TYPE : 4'($urandom)), (k[1] ? sel_pins : 3'($urandom)), 1'b1};
			xfer(1'b1, 1'b1, 1'b0, dev, dev[7:4] === TWS_DEV_TYPE && dev[3:1] === sel_pins);
			tick(6);
			check(standby, 1'b1);
		end
		// page write running past the 8-byte page end
		xfer(1'b1, 1'b0, 1'b0, {TWS_DEV_TYPE, sel_pins, 1'b0}, 1'b1);
		xfer(1'b0, 1'b0, 1'b0, 8'h0D, 1'b1);
		for (i = 0; i < 10; i++) begin
			pg[i] = 8'($urandom);
			xfer(1'b0, i == 9, 1'b0, pg[i], 1'b1);
		end
		prog_rise();
		prog_fall();
		// from 0D the last eight bytes wrap inside the 08..0F page
		for (i = 2; i < 10; i++) check(tws_slave_i.mem[11'(8 + (i + 5) % 8)], pg[i]);
		// bus recovery ahead of an addressed read
		xfer(1'b1, 1'b1, 1'b1, {TWS_DEV_TYPE, sel_pins, 1'b1}, 1'b1);
		tick(6);
		check(standby, 1'b1);
		conclude();
	end
endmodule // testbench
